// ### core/nsx_device.sv
// Device end of the synchronous cyclic exchange: cyclic data, sync pulse,
// control start, output routing and supply drop reporting.
// Assumes the master drives the link on i_core_clk and straps are stable.
//
// Operation
// - status captured each cycle, sent next cycle
// - received outputs applied at next cycle
// - master keeps sync cycle within 1ms..1000ms
// - master period is base times magnification
// - master base equals fixed scan interval
// - transient time at least 350us or 22us
// - class A refuses link; master logs event
// - sync mode fixed until power cycle
// - transfer control copies status into read area
// - transfer control applies write area words
// - sync register written one each cycle
// - copy output bits before control start
// - start request rise runs start processing
// - control active flag raised when started
// - outputs refreshed; select zero follows link
// - supply drop stores code, raises error flag
`timescale 1ns/1ns
`include "nsx_map.svh"
module nsx_device #(
  parameter int N_WORDS   = 128,
  parameter int N_OUT     = 96,
  parameter int N_GRP     = 6,
  parameter int START_LAT = 4
) (
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  // Link to the master
  nsx_link_if.dev                    link,
  // Straps read once after reset
  input  wire logic                  i_sync_mode,
  input  wire logic                  i_class_a,
  // Cyclic data with the user logic
  input  wire logic [N_WORDS*16-1:0] i_status_words,
  output logic      [N_WORDS*16-1:0] o_out_words,
  output logic      [15:0]           o_xfer_ctrl,
  output logic      [15:0]           o_sync_reg,
  output logic                       o_sync_pulse,
  output logic      [15:0]           o_run_ctrl,
  // Output routing
  input  wire logic [N_GRP-1:0]      i_out_select,
  input  wire logic [N_OUT-1:0]      i_user_out,
  output logic      [N_OUT-1:0]      o_out_value,
  output logic      [N_OUT-1:0]      o_phys_out,
  // Supply monitor
  input  wire logic                  i_supply_drop,
  input  wire logic                  i_drop_kind
);
  localparam int GW = N_OUT / N_GRP;
  localparam logic [7:0] LAT_LAST = 8'(START_LAT - 1);

  logic                  cfg_done;
  logic                  sync_mode;
  logic                  class_a;
  logic [N_WORDS*16-1:0] cap;
  logic [N_WORDS*16-1:0] tx;
  logic [N_WORDS*16-1:0] rcv;
  logic [7:0]            lat_cnt;
  logic                  active;
  logic [15:0]           err_code;
  logic                  err;
  logic                  start_rise;
  nsx_pkg::nsx_start_e   state;
  nsx_pkg::nsx_start_e   next_state;

  // Link status and the cycle strobe
  wire link_ok  = cfg_done & ~class_a;
  wire tick     = link_ok & (sync_mode ? link.sync_tick : 1'b1);
  wire sync_hit = link_ok & sync_mode & link.sync_tick;
  wire req_on   = link.start_req & link_ok;
  wire lat_done = (lat_cnt == LAT_LAST) & tick;

  // Straps are taken at the first edge after reset release and then held
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cfg_done  <= 1'b0;
      sync_mode <= 1'b0;
      class_a   <= 1'b0;
    end else if (!cfg_done) begin
      cfg_done  <= 1'b1;
      sync_mode <= i_sync_mode;
      class_a   <= i_class_a;
    end
  end

  // Transfer control pulses one cycle after each cycle boundary
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_xfer_ctrl <= '0;
    end else begin
      o_xfer_ctrl             <= '0;
      o_xfer_ctrl[`NSX_XF_RD] <= tick;
      o_xfer_ctrl[`NSX_XF_WR] <= tick;
    end
  end

  // Capture at the boundary; the write strobe applies the words of the previous
  // cycle and keeps this cycle's words, so outputs land one sync cycle later
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cap         <= '0;
      tx          <= '0;
      rcv         <= '0;
      o_out_words <= '0;
    end else begin
      if (tick) cap <= i_status_words;
      if (o_xfer_ctrl[`NSX_XF_RD]) tx <= cap;
      if (o_xfer_ctrl[`NSX_XF_WR]) begin
        o_out_words <= rcv;
        rcv         <= link.out_words;
      end
    end
  end

  // Sync register holds one for the cycle after each boundary in sync mode
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_sync_reg <= '0;
    end else begin
      o_sync_reg <= sync_hit ? `NSX_SYNC_VAL : '0;
    end
  end

  // One-cycle pulse to user logic per sync cycle
  nsx_rise u_sync_rise (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_level    (o_sync_reg[0]),
    .o_pulse    (o_sync_pulse)
  );

  // Start request edge, only while the link is up
  nsx_rise u_start_rise (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_level    (req_on),
    .o_pulse    (start_rise)
  );

  // Control start sequence
  always_comb begin
    next_state = state;
    unique case (state)
      nsx_pkg::S_IDLE: if (start_rise) next_state = nsx_pkg::S_COPY;
      nsx_pkg::S_COPY: next_state = nsx_pkg::S_WAIT;
      nsx_pkg::S_WAIT: if (lat_done) next_state = nsx_pkg::S_ACT;
      nsx_pkg::S_ACT:  next_state = nsx_pkg::S_ACT;
      default:         next_state = nsx_pkg::S_IDLE;
    endcase
    if (!req_on) next_state = nsx_pkg::S_IDLE;
  end

  // Sequence state and start latency count
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state   <= nsx_pkg::S_IDLE;
      lat_cnt <= '0;
    end else begin
      state <= next_state;
      if (state != nsx_pkg::S_WAIT) lat_cnt <= '0;
      else if (tick && !lat_done) lat_cnt <= lat_cnt + 8'h01;
    end
  end

  // Output values, run control and active flag
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_out_value <= '0;
      o_run_ctrl  <= `NSX_RUN_STOP;
      active      <= 1'b0;
    end else begin
      if (state == nsx_pkg::S_COPY) o_out_value <= link.out_bits;
      else if (state == nsx_pkg::S_ACT && tick) o_out_value <= link.out_bits;
      if (next_state == nsx_pkg::S_ACT) begin
        o_run_ctrl <= `NSX_RUN_START;
        active     <= 1'b1;
      end else begin
        o_run_ctrl <= `NSX_RUN_STOP;
        active     <= 1'b0;
      end
    end
  end

  // Per group routing: select zero follows the received bits
  genvar g;
  generate
    for (g = 0; g < N_GRP; g++) begin : grp
      assign o_phys_out[g*GW +: GW] = i_out_select[g] ? i_user_out[g*GW +: GW]
                                                      : o_out_value[g*GW +: GW];
    end
  endgenerate

  // Supply drop error: detection wins over a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      err_code <= '0;
      err      <= 1'b0;
    end else if (i_supply_drop) begin
      err_code <= i_drop_kind ? `NSX_ERR_DROP_B : `NSX_ERR_DROP_A;
      err      <= 1'b1;
    end else if (link.err_clear) begin
      err <= 1'b0;
    end
  end

  // Answers to the master
  assign link.in_words    = tx;
  assign link.ctrl_active = active;
  assign link.err_flag    = err;
  assign link.latest_err  = err_code;
  assign link.link_ok     = link_ok;
endmodule

// ### core/nsx_link_if.sv
// Link between the master station end and the device end.
// Assumes both ends share i_core_clk; the sync tick is a one-cycle pulse.
`timescale 1ns/1ns
interface nsx_link_if #(
  parameter int N_WORDS = 128,
  parameter int N_OUT   = 96
);
  logic                   sync_tick;
  logic                   start_req;
  logic                   err_clear;
  logic [N_WORDS*16-1:0]  out_words;
  logic [N_OUT-1:0]       out_bits;
  logic [N_WORDS*16-1:0]  in_words;
  logic                   ctrl_active;
  logic                   err_flag;
  logic                   link_ok;
  logic [15:0]            latest_err;
  modport dev (
    input  sync_tick, start_req, err_clear, out_words, out_bits,
    output in_words, ctrl_active, err_flag, link_ok, latest_err
  );
  modport mst (
    output sync_tick, start_req, err_clear, out_words, out_bits,
    input  in_words, ctrl_active, err_flag, link_ok, latest_err
  );
endinterface

// ### core/nsx_map.svh
// Constants of the synchronous cyclic exchange: codes, offsets, bit positions and times.
// Assumes inclusion by the package and both ends; definitions only.
`ifndef NSX_MAP_SVH
`define NSX_MAP_SVH
// Device register locations
`define NSX_A_RUN_CTRL   32'h1000_0002
`define NSX_A_OSEL_FIRST 32'h1000_4000
`define NSX_A_OSEL_LAST  32'h1000_400c
`define NSX_A_OVAL_FIRST 32'h1000_4010
`define NSX_A_OVAL_LAST  32'h1000_401c
`define NSX_A_XFER_CTRL  32'h1000_a000
`define NSX_A_SYNC_REG   32'h1000_a02a
`define NSX_A_WR_AREA    32'h1000_b300
`define NSX_A_RD_AREA    32'h1000_bb00
// Values written by the device; the class A event code is logged by the master
`define NSX_SYNC_VAL     16'h0001
`define NSX_RUN_START    16'h0001
`define NSX_RUN_STOP     16'h0000
`define NSX_ERR_DROP_A   16'h1080
`define NSX_ERR_DROP_B   16'h1081
`define NSX_EVT_CLASS_A  32'h0000_0c71
// Transfer control bits
`define NSX_XF_RD        0
`define NSX_XF_WR        1
// Controller register offsets
`define NSX_R_CTRL       8'h00
`define NSX_R_BASE       8'h04
`define NSX_R_MAG        8'h08
`define NSX_R_STAT       8'h0c
`define NSX_R_ISTAT      8'h10
`define NSX_R_IMASK      8'h14
`define NSX_R_EVENT      8'h18
// Control bits
`define NSX_C_START      0
`define NSX_C_EN         1
`define NSX_C_ERRCLR     2
// Interrupt bits
`define NSX_I_TICK       0
`define NSX_I_ACTIVE     1
`define NSX_I_ERR        2
`define NSX_I_REFUSE     3
// Reset values, times and bus response codes
`define NSX_BASE_RST     32'h0001_e848
`define NSX_MAG_RST      8'h01
`define NSX_CLK_NS       8
`define NSX_MIN_SYNC_NS  1000000
`define NSX_MAX_SYNC_NS  1000000000
`define NSX_RESP_OK      2'h0
`define NSX_RESP_ERR     2'h2
`endif

// ### core/nsx_master.sv
// Master station end: sync cycle generator, cyclic data and an AXI4-Lite
// register file for software, with a level interrupt.
// Assumes one clock shared with the device and the AXI4-Lite master.
`timescale 1ns/1ns
`include "nsx_map.svh"
module nsx_master #(
  parameter int                  N_WORDS = 128,
  parameter int                  N_OUT   = 96,
  parameter logic [39:0]         MIN_CYC = 40'((`NSX_MIN_SYNC_NS + `NSX_CLK_NS - 1) / `NSX_CLK_NS),
  parameter logic [39:0]         MAX_CYC = 40'(`NSX_MAX_SYNC_NS / `NSX_CLK_NS)
) (
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Link to the device
  nsx_link_if.mst                    link,
  // Cyclic data with the user side
  input  wire logic [N_WORDS*16-1:0] i_out_words,
  input  wire logic [N_OUT-1:0]      i_out_bits,
  output logic      [N_WORDS*16-1:0] o_in_words,
  // Interrupt
  output logic                       o_irq
);
  logic [2:0]  ctrl;
  logic [31:0] base;
  logic [7:0]  mag;
  logic [3:0]  istat;
  logic [3:0]  imask;
  logic [31:0] event_code;
  logic [39:0] cnt;
  logic [1:0]  prev;
  logic        ref_prev;

  // Cycle length: base times magnification, held within the legal range
  wire [39:0] prod   = base * mag;
  wire [39:0] period = (prod < MIN_CYC) ? MIN_CYC : (prod > MAX_CYC) ? MAX_CYC : prod;
  wire        tick   = ctrl[`NSX_C_EN] & (cnt >= period - 40'h1);

  // Bus decode
  wire wr_go  = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_go  = s_axi_arvalid & ~s_axi_rvalid;
  wire w_ctrl = wr_go & (s_axi_awaddr == `NSX_R_CTRL);
  wire w_base = wr_go & (s_axi_awaddr == `NSX_R_BASE);
  wire w_mag  = wr_go & (s_axi_awaddr == `NSX_R_MAG);
  wire w_ist  = wr_go & (s_axi_awaddr == `NSX_R_ISTAT);
  wire w_imk  = wr_go & (s_axi_awaddr == `NSX_R_IMASK);
  wire w_ok   = (s_axi_awaddr <= `NSX_R_EVENT) & (s_axi_awaddr[1:0] == 2'h0);
  wire r_ok   = (s_axi_araddr <= `NSX_R_EVENT) & (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] stat = {link.latest_err, 13'h0, link.link_ok, link.err_flag, link.ctrl_active};
  wire [31:0] rd_mux =
    (s_axi_araddr == `NSX_R_CTRL)  ? {29'h0, ctrl}  :
    (s_axi_araddr == `NSX_R_BASE)  ? base           :
    (s_axi_araddr == `NSX_R_MAG)   ? {24'h0, mag}   :
    (s_axi_araddr == `NSX_R_STAT)  ? stat           :
    (s_axi_araddr == `NSX_R_ISTAT) ? {28'h0, istat} :
    (s_axi_araddr == `NSX_R_IMASK) ? {28'h0, imask} :
    (s_axi_araddr == `NSX_R_EVENT) ? event_code     : 32'h0;
  wire refused = ctrl[`NSX_C_START] & ~link.link_ok;
  wire [3:0] ev = {refused & ~ref_prev, link.err_flag & ~prev[1],
                   link.ctrl_active & ~prev[0], tick};

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign o_irq         = |(istat & imask);

  // Writable registers; the error clear bit is a one-cycle pulse
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ctrl  <= '0;
      base  <= `NSX_BASE_RST;
      mag   <= `NSX_MAG_RST;
      imask <= '0;
    end else begin
      ctrl[`NSX_C_ERRCLR] <= 1'b0;
      if (w_ctrl && s_axi_wstrb[0]) ctrl <= s_axi_wdata[2:0];
      if (w_base) base <= s_axi_wdata;
      if (w_mag && s_axi_wstrb[0]) mag <= s_axi_wdata[7:0];
      if (w_imk && s_axi_wstrb[0]) imask <= s_axi_wdata[3:0];
    end
  end

  // Sticky events, write one to clear; a new event wins
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      istat      <= '0;
      prev       <= '0;
      ref_prev   <= 1'b0;
      event_code <= '0;
    end else begin
      istat    <= (istat & ~((w_ist && s_axi_wstrb[0]) ? s_axi_wdata[3:0] : 4'h0)) | ev;
      prev     <= {link.err_flag, link.ctrl_active};
      ref_prev <= refused;
      if (refused && !ref_prev) event_code <= `NSX_EVT_CLASS_A;
    end
  end

  // Bus answers one cycle after acceptance
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `NSX_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `NSX_RESP_OK;
      s_axi_rdata  <= '0;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_ok ? `NSX_RESP_OK : `NSX_RESP_ERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= r_ok ? `NSX_RESP_OK : `NSX_RESP_ERR;
        s_axi_rdata  <= rd_mux;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // Sync cycle generator and cyclic data exchange at each boundary
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cnt            <= '0;
      link.sync_tick <= 1'b0;
      link.out_words <= '0;
      link.out_bits  <= '0;
      o_in_words     <= '0;
    end else begin
      cnt            <= (tick || !ctrl[`NSX_C_EN]) ? 40'h0 : cnt + 40'h1;
      link.sync_tick <= tick;
      if (tick) begin
        link.out_words <= i_out_words;
        link.out_bits  <= i_out_bits;
        o_in_words     <= link.in_words;
      end
    end
  end

  assign link.start_req = ctrl[`NSX_C_START];
  assign link.err_clear = ctrl[`NSX_C_ERRCLR];
endmodule

// ### core/nsx_pkg.sv
// Types of the cyclic exchange, used by the device end only.
// Assumes nsx_map.svh for the numeric constants.
`include "nsx_map.svh"
package nsx_pkg;
  typedef logic [15:0] nsx_word_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_COPY = 4'h2,
    S_WAIT = 4'h4,
    S_ACT  = 4'h8
  } nsx_start_e;
endpackage

// ### core/nsx_rise.sv
// Rising edge to one-cycle registered pulse.
// Assumes the level is synchronous to i_core_clk.
`timescale 1ns/1ns
module nsx_rise (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  // Level in, pulse out
  input  wire logic i_level,
  output logic      o_pulse
);
  logic prev;
  // Remember the level and flag its rise
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      prev    <= 1'b0;
      o_pulse <= 1'b0;
    end else begin
      prev    <= i_level;
      o_pulse <= i_level & ~prev;
    end
  end
endmodule

// ### verif/network_sync_cyclic_exchange_tb.sv
// Bench for the cyclic exchange: master and device joined by the link.
// Assumes the design under core/ and the link checker; software side over AXI4-Lite.
`timescale 1ns/1ns
`include "nsx_map.svh"
module network_sync_cyclic_exchange_tb;
  localparam int NW = 4;
  localparam int NO = 96;
  // Clock, reset, bus and user side signals
  logic              i_core_clk = 1'b0;
  logic              i_rstn     = 1'b0;
  logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]       wdata = 32'h0, rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic              rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              sync_mode = 1'b1, class_a = 1'b0, drop = 1'b0, kind = 1'b0;
  logic [NW*16-1:0]  stat_w = '0, m_out_w = '0, dev_out_w, m_in_w;
  logic [NO-1:0]     bits = '0, uout = '0, oval, phys;
  logic [5:0]        osel = 6'h00;
  logic [15:0]       xfer, sreg, run;
  logic              spulse, irq;
  logic [31:0]       seed = 32'h93b21fec;
  int                fails = 0, checks = 0;

  // Clock
  always #4 i_core_clk = ~i_core_clk;

  nsx_link_if #(.N_WORDS(NW), .N_OUT(NO)) link ();
  nsx_master #(.N_WORDS(NW), .N_OUT(NO), .MIN_CYC(40'd8), .MAX_CYC(40'd64)) nsx_master_inst (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link.mst), .i_out_words(m_out_w), .i_out_bits(bits), .o_in_words(m_in_w), .o_irq(irq));
  nsx_device #(.N_WORDS(NW), .N_OUT(NO), .N_GRP(6), .START_LAT(4)) nsx_device_inst (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .link(link.dev), .i_sync_mode(sync_mode),
    .i_class_a(class_a), .i_status_words(stat_w), .o_out_words(dev_out_w), .o_xfer_ctrl(xfer),
    .o_sync_reg(sreg), .o_sync_pulse(spulse), .o_run_ctrl(run), .i_out_select(osel),
    .i_user_out(uout), .o_out_value(oval), .o_phys_out(phys), .i_supply_drop(drop),
    .i_drop_kind(kind));
  nsx_link_chk #(.N_WORDS(NW), .N_OUT(NO)) nsx_link_chk_inst (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .sync_tick(link.sync_tick),
    .start_req(link.start_req), .err_clear(link.err_clear), .out_words(link.out_words),
    .out_bits(link.out_bits), .in_words(link.in_words), .ctrl_active(link.ctrl_active),
    .err_flag(link.err_flag), .link_ok(link.link_ok), .latest_err(link.latest_err));

  // Random source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk_val(input logic [127:0] got, input logic [127:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Cut a hang short
  task automatic tmo(input int n, input string what);
    if (n >= 400) begin
      fails++;
      $display("[FAIL] %0t timeout waiting for %s", $time, what);
      test_done();
    end
  endtask

  // Bus write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_core_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (!(awready === 1'b1 && wready === 1'b1) && n < 400);
    tmo(n, "write address");
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (bvalid !== 1'b1 && n < 400);
    tmo(n, "write response");
    r = bresp;
    bready <= 1'b0;
  endtask

  // Bus read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (arready !== 1'b1 && n < 400);
    tmo(n, "read address");
    arvalid <= 1'b0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (rvalid !== 1'b1 && n < 400);
    tmo(n, "read data");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Find a tick, check the sync outputs after it, return the gap in cycles
  task automatic wait_tick(output int gap);
    int n;
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1;
      n++;
    end while (link.sync_tick !== 1'b1 && n < 400);
    tmo(n, "tick");
    @(posedge i_core_clk);
    #1;
    chk_val(xfer, 16'h0003, "transfer control");
    chk_val(sreg, `NSX_SYNC_VAL, "sync register");
    @(posedge i_core_clk);
    #1;
    chk_val(spulse, 1'b1, "sync pulse");
    @(posedge i_core_clk);
    #1;
    chk_val({sreg, spulse}, 17'h0, "sync pulse width");
    gap = n + 3;
  endtask

  // Main sequence
  initial begin
    logic [1:0]       r;
    logic [31:0]      d;
    logic [NW*16-1:0] s, w;
    logic [NO-1:0]    u, e;
    logic [NW*16-1:0] qs[$];
    logic [NW*16-1:0] qw[$];
    int               g, k, p;
    static int        pb[4] = '{10, 2, 30, 5};
    static int        pm[4] = '{1, 3, 3, 4};
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    axi_rd(`NSX_R_BASE, d, r);
    chk_val(d, `NSX_BASE_RST, "base reset");
    axi_rd(`NSX_R_MAG, d, r);
    chk_val(d, 32'(`NSX_MAG_RST), "mag reset");
    axi_rd(8'h1c, d, r);
    chk_val({d, r}, {32'h0, `NSX_RESP_ERR}, "unmapped read");
    axi_wr(8'h06, 32'h1, r);
    chk_val(r, `NSX_RESP_ERR, "misaligned write");
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      axi_wr(`NSX_R_BASE, 32'(pb[i]), r);
      axi_wr(`NSX_R_MAG, 32'(pm[i]), r);
      axi_wr(`NSX_R_CTRL, 32'h2, r);
      wait_tick(g);
      wait_tick(g);
      p = pb[i] * pm[i];
      p = (p < 8) ? 8 : ((p > 64) ? 64 : p);
      chk_val(g, p, "sync period");
    end
    $display("test period done");
    bits <= {rnd(), rnd(), rnd()};
    for (int i = 0; i < 6; i++) begin
      wait_tick(g);
      if (qs.size() == 2) begin
        chk_val(m_in_w, qs.pop_front(), "status words");
        chk_val(dev_out_w, qw.pop_front(), "output words");
      end
      s = {rnd(), rnd()};
      w = {rnd(), rnd()};
      qs.push_back(s);
      qw.push_back(w);
      @(posedge i_core_clk);
      stat_w    <= s;
      m_out_w   <= w;
      sync_mode <= 1'b0;
    end
    $display("test cyclic done");
    axi_wr(`NSX_R_CTRL, 32'h3, r);
    k = 0;
    while (link.ctrl_active !== 1'b1 && k < 8) begin
      wait_tick(g);
      k++;
      if (k == 2) chk_val(oval, bits, "copied outputs");
    end
    chk_val(k inside {[4:5]}, 1'b1, "start latency");
    chk_val(run, `NSX_RUN_START, "run control");
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      u = {rnd(), rnd(), rnd()};
      @(posedge i_core_clk);
      osel <= d[5:0];
      uout <= u;
      @(posedge i_core_clk);
      #1;
      for (int j = 0; j < 6; j++) e[16*j +: 16] = d[j] ? u[16*j +: 16] : bits[16*j +: 16];
      chk_val(phys, e, "output routing");
    end
    chk_val(irq, 1'b0, "irq masked");
    axi_wr(`NSX_R_IMASK, 32'h2, r);
    #1;
    chk_val(irq, 1'b1, "irq raised");
    axi_wr(`NSX_R_ISTAT, 32'h2, r);
    #1;
    chk_val(irq, 1'b0, "irq cleared");
    axi_wr(`NSX_R_CTRL, 32'h2, r);
    repeat (3) @(posedge i_core_clk);
    #1;
    chk_val({run, link.ctrl_active}, {`NSX_RUN_STOP, 1'b0}, "stop");
    $display("test start done");
    d = rnd();
    @(posedge i_core_clk);
    drop <= 1'b1;
    kind <= d[0];
    @(posedge i_core_clk);
    drop <= 1'b0;
    axi_rd(`NSX_R_STAT, d, r);
    chk_val(d[31:16], kind ? `NSX_ERR_DROP_B : `NSX_ERR_DROP_A, "drop code");
    chk_val(d[1], 1'b1, "error flag");
    axi_wr(`NSX_R_CTRL, 32'h6, r);
    axi_rd(`NSX_R_STAT, d, r);
    chk_val(d[1], 1'b0, "error clear");
    $display("test supply done");
    @(posedge i_core_clk);
    i_rstn    <= 1'b0;
    class_a   <= 1'b1;
    sync_mode <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    axi_wr(`NSX_R_CTRL, 32'h3, r);
    repeat (30) @(posedge i_core_clk);
    axi_rd(`NSX_R_STAT, d, r);
    chk_val(d[2:0], 3'b000, "link refused");
    axi_rd(`NSX_R_EVENT, d, r);
    chk_val(d, `NSX_EVT_CLASS_A, "refusal event");
    $display("test class done");
    test_done();
  end
endmodule

// ### verif/nsx_link_chk.sv
// Concurrent checks on the link that joins the master end and the device end.
// Assumes the link signals arrive as plain inputs in one clock domain.
`timescale 1ns/1ns
`include "nsx_map.svh"
module nsx_link_chk #(
  parameter int N_WORDS = 128,
  parameter int N_OUT   = 96
) (
  // Clock and reset
  input wire logic                   i_core_clk,
  input wire logic                   i_rstn,
  // Master to device
  input wire logic                   sync_tick,
  input wire logic                   start_req,
  input wire logic                   err_clear,
  input wire logic [N_WORDS*16-1:0]  out_words,
  input wire logic [N_OUT-1:0]       out_bits,
  // Device to master
  input wire logic [N_WORDS*16-1:0]  in_words,
  input wire logic                   ctrl_active,
  input wire logic                   err_flag,
  input wire logic                   link_ok,
  input wire logic [15:0]            latest_err
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  // Tick lasts one cycle and the next one is at least eight cycles away
  chk_tick_spacing: assert property (sync_tick |=> !sync_tick [*7])
    else $error("sync ticks closer than the shortest cycle");
  // Status words move only two cycles after a tick
  chk_status_timing: assert property (!$stable(in_words) |-> $past(sync_tick, 2))
    else $error("status words changed away from a tick");
  // Output words move only around a tick
  chk_output_load: assert property (!$stable(out_words) |-> sync_tick || $past(sync_tick))
    else $error("output words changed away from a tick");
  // Active flag rises only under a request on an established link
  chk_active_cause: assert property ($rose(ctrl_active) |-> start_req && link_ok)
    else $error("active flag rose without request");
  // Start processing takes several ticks
  chk_start_wait: assert property ($rose(ctrl_active) |-> $past(start_req, 20))
    else $error("active flag rose too soon after request");
  // Withdrawn request leaves control inactive
  chk_stop_drop: assert property (!start_req [*2] |-> !ctrl_active)
    else $error("active flag held without request");
  // A refused link never becomes active
  chk_link_refuse: assert property (!link_ok |-> !ctrl_active)
    else $error("active flag without link");
  // Error flag carries a supply drop code
  chk_err_code: assert property (err_flag |-> latest_err inside {`NSX_ERR_DROP_A, `NSX_ERR_DROP_B})
    else $error("error flag without drop code");
  // Error flag falls only after a clear pulse
  chk_err_clear: assert property ($fell(err_flag) |-> $past(err_clear))
    else $error("error flag fell without clear");
endmodule
